// >>> src/ptb_pwm_regs.vh
`ifndef PTB_PWM_REGS_VH
`define PTB_PWM_REGS_VH

// register indices (byte address = index * 4)
`define PTB_IDX_COUNTER 4'h0
`define PTB_IDX_PERIOD 4'h1
`define PTB_IDX_TBCTRL 4'h2
`define PTB_IDX_U1DUTY 4'h3
`define PTB_IDX_U1SHADOW 4'h4
`define PTB_IDX_U1CTRL 4'h5
`define PTB_IDX_U2DUTY 4'h6
`define PTB_IDX_U2SHADOW 4'h7
`define PTB_IDX_U2CTRL 4'h8
`define PTB_IDX_DIR 4'h9

// reset values
`define PTB_RST_COUNTER 8'h00
`define PTB_RST_PERIOD 8'hFF
`define PTB_RST_TBCTRL 7'h00
`define PTB_RST_UCTRL 6'h00
`define PTB_RST_DUTY 8'h00
`define PTB_RST_DIR 2'h3

// unit control fields
`define PTB_UC_DUTYLO_HI 5
`define PTB_UC_DUTYLO_LO 4
`define PTB_UC_MODE_HI 3
`define PTB_UC_MODE_LO 0
`define PTB_MODE_PWM 2'h3

// timebase control fields
`define PTB_TB_RUN 2
`define PTB_TB_PS_HI 1
`define PTB_TB_PS_LO 0
`define PTB_PS_DIV1 2'h0
`define PTB_PS_DIV4 2'h1

// prescaler terminal counts
`define PTB_PS_LAST1 4'h0
`define PTB_PS_LAST4 4'h3
`define PTB_PS_LAST16 4'hF

`endif

// >>> src/ptb_prescaler.v
`timescale 1ns/10ps
`include "ptb_pwm_regs.vh"

module ptb_prescaler
(
   // clock and reset
   input wire core_clk,
   input wire arst_n,
   // control
   input wire run,
   input wire [1:0] divSel,
   // outputs
   output wire tick,
   output wire [1:0] subCount
);

reg [3:0] psCnt_ff;
reg [3:0] lastCnt;
wire [3:0] nxt_psCnt;

always @*
begin
   case (divSel)
      `PTB_PS_DIV1: lastCnt = `PTB_PS_LAST1;
      `PTB_PS_DIV4: lastCnt = `PTB_PS_LAST4;
      default: lastCnt = `PTB_PS_LAST16;
   endcase
end

assign tick = run && (psCnt_ff >= lastCnt);
assign nxt_psCnt = tick ? 4'h0 : (run ? psCnt_ff + 4'h1 : psCnt_ff);

always @(posedge core_clk or negedge arst_n)
begin
   if (!arst_n)
      psCnt_ff <= 4'h0;
   else
      psCnt_ff <= nxt_psCnt;
end

// the two lower bits of the sub-count extend the counter to 10 bits;
// with divide-by-16 they are the top two prescaler bits
assign subCount = (divSel == `PTB_PS_DIV1) ? 2'h0 :
                  (divSel == `PTB_PS_DIV4) ? psCnt_ff[1:0] :
                  psCnt_ff[3:2];

endmodule // ptb_prescaler

// >>> src/ptb_duty_unit.v
`timescale 1ns/10ps
`include "ptb_pwm_regs.vh"

module ptb_duty_unit
(
   // clock and reset
   input wire core_clk,
   input wire arst_n,
   // configuration
   input wire pwmMode,
   input wire ctrlZero,
   input wire [9:0] dutyWritten,
   // timebase
   input wire periodEnd,
   input wire [9:0] extCount,
   // results
   output wire [7:0] shadowByte,
   output wire pwmLevel
);

reg [7:0] shadow_ff;
reg [1:0] latchLo_ff;
reg out_ff;
reg [7:0] nxt_shadow;
reg [1:0] nxt_latchLo;
reg nxt_out;

always @*
begin
   nxt_shadow = shadow_ff;
   nxt_latchLo = latchLo_ff;
   nxt_out = out_ff;
   if (ctrlZero || !pwmMode)
      nxt_out = 1'b0;
   else if (periodEnd)
   begin
      nxt_shadow = dutyWritten[9:2];
      nxt_latchLo = dutyWritten[1:0];
      nxt_out = (dutyWritten != 10'h000);
   end
   // never matches if duty exceeds period, so output stays high
   else if ({shadow_ff, latchLo_ff} == extCount)
      nxt_out = 1'b0;
end

always @(posedge core_clk or negedge arst_n)
begin
   if (!arst_n)
   begin
      shadow_ff <= `PTB_RST_DUTY;
      latchLo_ff <= 2'h0;
      out_ff <= 1'b0;
   end
   else
   begin
      shadow_ff <= nxt_shadow;
      latchLo_ff <= nxt_latchLo;
      out_ff <= nxt_out;
   end
end

assign shadowByte = shadow_ff;
assign pwmLevel = out_ff;

endmodule // ptb_duty_unit

// >>> src/ptb_pwm_timebase.v
`timescale 1ns/10ps
`include "ptb_pwm_regs.vh"

////////////////////////////////////////////////////////////////////////////
module ptb_pwm_timebase
(
   // clock and reset
   input wire core_clk,
   input wire arst_n,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [5:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output wire [31:0] wb_dat_o,
   output wire wb_ack_o,
   output wire wb_err_o,
   // pwm pins, output enable low while driving
   output wire pwmOneOut,
   output wire pwmOneOe_n,
   output wire pwmTwoOut,
   output wire pwmTwoOe_n
);

////////////////////////////////////////////////////////////////////////////
// bus decode

reg ack_ff;
reg err_ff;
reg [31:0] rdData_ff;
reg [7:0] counter_ff;
reg [7:0] period_ff;
reg [6:0] tbCtrl_ff;
reg [7:0] duty1_ff;
reg [7:0] duty2_ff;
reg [5:0] ctrl1_ff;
reg [5:0] ctrl2_ff;
reg [1:0] dir_ff;
reg [7:0] nxt_counter;
reg [31:0] nxt_rdData;
reg nxt_mapped;

wire [3:0] regIdx;
wire busReq;
wire wrLane0;
wire wrStrobe;
wire [7:0] shadow1;
wire [7:0] shadow2;
wire pwmLevel1;
wire pwmLevel2;
wire psTick;
wire [1:0] psSub;
wire periodMatch;
wire periodEnd;
wire [9:0] extCount;
wire timebaseRun;

assign regIdx = wb_adr_i[5:2];
// one request per strobe; ack drops in the cycle after it was given
assign busReq = wb_cyc_i && wb_stb_i && !ack_ff && !err_ff;
assign wrLane0 = wb_sel_i[0];

always @*
begin
   nxt_mapped = 1'b1;
   nxt_rdData = 32'h0000_0000;
   case (regIdx)
      `PTB_IDX_COUNTER: nxt_rdData[7:0] = counter_ff;
      `PTB_IDX_PERIOD: nxt_rdData[7:0] = period_ff;
      `PTB_IDX_TBCTRL: nxt_rdData[6:0] = tbCtrl_ff;
      `PTB_IDX_U1DUTY: nxt_rdData[7:0] = duty1_ff;
      `PTB_IDX_U1SHADOW: nxt_rdData[7:0] = shadow1;
      `PTB_IDX_U1CTRL: nxt_rdData[5:0] = ctrl1_ff;
      `PTB_IDX_U2DUTY: nxt_rdData[7:0] = duty2_ff;
      `PTB_IDX_U2SHADOW: nxt_rdData[7:0] = shadow2;
      `PTB_IDX_U2CTRL: nxt_rdData[5:0] = ctrl2_ff;
      `PTB_IDX_DIR: nxt_rdData[1:0] = dir_ff;
      default: nxt_mapped = 1'b0;
   endcase
end

assign wrStrobe = busReq && wb_we_i && wrLane0 && nxt_mapped;

always @(posedge core_clk or negedge arst_n)
begin
   if (!arst_n)
   begin
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
      rdData_ff <= 32'h0000_0000;
   end
   else
   begin
      ack_ff <= busReq && nxt_mapped;
      err_ff <= busReq && !nxt_mapped;
      rdData_ff <= (busReq && !wb_we_i) ? nxt_rdData : rdData_ff;
   end
end

assign wb_ack_o = ack_ff;
assign wb_err_o = err_ff;
assign wb_dat_o = rdData_ff;

////////////////////////////////////////////////////////////////////////////
// software registers

always @(posedge core_clk or negedge arst_n)
begin
   if (!arst_n)
   begin
      period_ff <= `PTB_RST_PERIOD;
      tbCtrl_ff <= `PTB_RST_TBCTRL;
      duty1_ff <= `PTB_RST_DUTY;
      duty2_ff <= `PTB_RST_DUTY;
      ctrl1_ff <= `PTB_RST_UCTRL;
      ctrl2_ff <= `PTB_RST_UCTRL;
      dir_ff <= `PTB_RST_DIR;
   end
   else if (wrStrobe)
   begin
      // shadow registers take no write
      case (regIdx)
         `PTB_IDX_PERIOD: period_ff <= wb_dat_i[7:0];
         `PTB_IDX_TBCTRL: tbCtrl_ff <= wb_dat_i[6:0];
         `PTB_IDX_U1DUTY: duty1_ff <= wb_dat_i[7:0];
         `PTB_IDX_U1CTRL: ctrl1_ff <= wb_dat_i[5:0];
         `PTB_IDX_U2DUTY: duty2_ff <= wb_dat_i[7:0];
         `PTB_IDX_U2CTRL: ctrl2_ff <= wb_dat_i[5:0];
         `PTB_IDX_DIR: dir_ff <= wb_dat_i[1:0];
         default: dir_ff <= dir_ff;
      endcase
   end
end

////////////////////////////////////////////////////////////////////////////
// shared timebase

assign timebaseRun = tbCtrl_ff[`PTB_TB_RUN];

// postscaler bits 6:3 are stored and read back over the bus but never used by the timebase
ptb_prescaler u_prescaler
(
   .core_clk(core_clk),
   .arst_n(arst_n),
   .run(timebaseRun),
   .divSel(tbCtrl_ff[`PTB_TB_PS_HI:`PTB_TB_PS_LO]),
   .tick(psTick),
   .subCount(psSub)
);

assign periodMatch = (counter_ff == period_ff);
assign periodEnd = psTick && periodMatch;
assign extCount = {counter_ff, psSub};

always @*
begin
   nxt_counter = counter_ff;
   if (wrStrobe && regIdx == `PTB_IDX_COUNTER)
      nxt_counter = wb_dat_i[7:0];
   else if (periodEnd)
      nxt_counter = `PTB_RST_COUNTER;
   else if (psTick)
      nxt_counter = counter_ff + 8'h01;
end

always @(posedge core_clk or negedge arst_n)
begin
   if (!arst_n)
      counter_ff <= `PTB_RST_COUNTER;
   else
      counter_ff <= nxt_counter;
end

////////////////////////////////////////////////////////////////////////////
// duty units, both on the same timebase

ptb_duty_unit u_unit_one
(
   .core_clk(core_clk),
   .arst_n(arst_n),
   .pwmMode(ctrl1_ff[`PTB_UC_MODE_HI:2] == `PTB_MODE_PWM),
   .ctrlZero(ctrl1_ff == `PTB_RST_UCTRL),
   .dutyWritten({duty1_ff,
                 ctrl1_ff[`PTB_UC_DUTYLO_HI:`PTB_UC_DUTYLO_LO]}),
   .periodEnd(periodEnd),
   .extCount(extCount),
   .shadowByte(shadow1),
   .pwmLevel(pwmLevel1)
);

ptb_duty_unit u_unit_two
(
   .core_clk(core_clk),
   .arst_n(arst_n),
   .pwmMode(ctrl2_ff[`PTB_UC_MODE_HI:2] == `PTB_MODE_PWM),
   .ctrlZero(ctrl2_ff == `PTB_RST_UCTRL),
   .dutyWritten({duty2_ff,
                 ctrl2_ff[`PTB_UC_DUTYLO_HI:`PTB_UC_DUTYLO_LO]}),
   .periodEnd(periodEnd),
   .extCount(extCount),
   .shadowByte(shadow2),
   .pwmLevel(pwmLevel2)
);

// direction bit 0 gates unit one, bit 1 unit two; 0 makes the pin drive
assign pwmOneOut = pwmLevel1;
assign pwmOneOe_n = dir_ff[0];
assign pwmTwoOut = pwmLevel2;
assign pwmTwoOe_n = dir_ff[1];

endmodule // ptb_pwm_timebase

// >>> tb/ptb_pwm_timebase_checker.sv
`timescale 1ns/10ps
module ptb_pwm_timebase_checker
(
   // clock and reset
   input wire core_clk,
   input wire arst_n,
   // wishbone
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [5:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire wb_err_o,
   // pwm pins
   input wire pwmOneOut,
   input wire pwmOneOe_n,
   input wire pwmTwoOut,
   input wire pwmTwoOe_n
);
default clocking @(posedge core_clk); endclocking
default disable iff (!arst_n);
wire taken = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
wire wr = taken & wb_we_i & wb_sel_i[0];
////////////////////////////////////////////////////////////////////////////
AST_ANSWER:
   assert property (taken |=> wb_ack_o ^ wb_err_o) else $error("no answer");
AST_UNMAPPED:
   assert property (taken && wb_adr_i[5:2] > 4'h9 |=> wb_err_o)
   else $error("unmapped not refused");
AST_MAPPED:
   assert property (taken && wb_adr_i[5:2] <= 4'h9 |=> wb_ack_o)
   else $error("mapped not acked");
AST_ACK_PULSE:
   assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
AST_READ_UPPER:
   assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
   else $error("upper read bits set");
AST_OFF_ONE:
   assert property (wr && wb_adr_i == 6'h14 && wb_dat_i[7:0] == 8'h00
      |=> ##2 !pwmOneOut) else $error("unit one not forced low");
AST_OFF_TWO:
   assert property (wr && wb_adr_i == 6'h20 && wb_dat_i[7:0] == 8'h00
      |=> ##2 !pwmTwoOut) else $error("unit two not forced low");
AST_DIR_ONE:
   assert property (wr && wb_adr_i == 6'h24
      |=> ##2 pwmOneOe_n == $past(wb_dat_i[0], 3))
   else $error("unit one enable wrong");
AST_DIR_TWO:
   assert property (wr && wb_adr_i == 6'h24
      |=> ##2 pwmTwoOe_n == $past(wb_dat_i[1], 3))
   else $error("unit two enable wrong");
endmodule // ptb_pwm_timebase_checker

// >>> tb/ptb_pwm_timebase_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm,ex,gt) begin compares++; if ((gt) !== (ex)) begin mismatches++; \
 $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module ptb_pwm_timebase_tb_top;
reg core_clk = 1'h0;
reg arst_n = 1'h0;
reg cyc = 1'h0;
reg stb = 1'h0;
reg we = 1'h0;
reg [5:0] adr = 6'h00;
reg [31:0] datW = 32'h00000000;
wire [31:0] datR;
wire ack, err, oneOut, oneOe_n, twoOut, twoOe_n;
integer mismatches = 0;
integer compares = 0;
integer cycles = 0;
reg [31:0] rd;
reg rdErr;
ptb_pwm_timebase dut
(
   .core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
   .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(datW),
   .wb_dat_o(datR), .wb_ack_o(ack), .wb_err_o(err), .pwmOneOut(oneOut),
   .pwmOneOe_n(oneOe_n), .pwmTwoOut(twoOut), .pwmTwoOe_n(twoOe_n)
);
always #5 core_clk = ~core_clk;
// a hung bus wait ends here
always @(posedge core_clk)
begin
   cycles++;
   if (cycles == 3000)
   begin
      mismatches++;
      finish_test;
   end
end
////////////////////////////////////////////////////////////////////////////
task bus(input [3:0] idx, input w, input [7:0] d);
begin
   @(posedge core_clk);
   cyc <= 1'h1;
   stb <= 1'h1;
   we <= w;
   adr <= {idx, 2'h0};
   datW <= {24'h000000, d};
   do @(posedge core_clk); while (ack !== 1'h1 && err !== 1'h1);
   rd = datR;
   rdErr = err;
   cyc <= 1'h0;
   stb <= 1'h0;
end
endtask
task rchk(input [3:0] idx, input [7:0] ex);
begin
   bus(idx, 1'h0, 8'h00);
   `CHK("register", {24'h000000, ex}, rd)
end
endtask
// whole periods only, so the window phase cannot skew the counts
task meas(input integer h1, input integer r1, input integer h2);
integer a, b, c;
reg p;
begin
   a = 0;
   b = 0;
   c = 0;
   p = oneOut;
   repeat (128)
   begin
      @(posedge core_clk);
      a += oneOut;
      b += oneOut & !p;
      p = oneOut;
      c += twoOut;
   end
   `CHK("high one", h1, a)
   `CHK("rise one", r1, b)
   `CHK("high two", h2, c)
end
endtask
////////////////////////////////////////////////////////////////////////////
task t_regs;
begin
   rchk(4'h0, 8'h00);
   rchk(4'h1, 8'hFF);
   rchk(4'h2, 8'h00);
   rchk(4'h5, 8'h00);
   rchk(4'h8, 8'h00);
   rchk(4'h9, 8'h03);
   bus(4'hA, 1'h1, 8'h55);
   `CHK("unmapped", 1'h1, rdErr)
   bus(4'h4, 1'h1, 8'hAA);
   rchk(4'h4, 8'h00);
end
endtask
task t_fast;
begin
   // set-up order: period, duty, direction, timebase, then mode
   bus(4'h1, 1'h1, 8'h03);
   bus(4'h3, 1'h1, 8'h02);
   bus(4'h6, 1'h1, 8'h05);
   bus(4'h9, 1'h1, 8'h00);
   rchk(4'h9, 8'h00);
   `CHK("enables", 2'h0, {oneOe_n, twoOe_n})
   bus(4'h2, 1'h1, 8'h04);
   bus(4'h5, 1'h1, 8'h0C);
   bus(4'h8, 1'h1, 8'h0C);
   repeat (160) @(posedge core_clk);
   // the registered pin falls one clock after the match: duty + 1 clocks
   meas(96, 32, 128);
   rchk(4'h4, 8'h02);
   rchk(4'h7, 8'h05);
end
endtask
task t_mid;
begin
   bus(4'h6, 1'h1, 8'h00);
   bus(4'h5, 1'h1, 8'h1D);
   // postscale field set too: the period must not move
   bus(4'h2, 1'h1, 8'h7D);
   repeat (160) @(posedge core_clk);
   meas(80, 8, 0);
end
endtask
task t_slow;
begin
   bus(4'h6, 1'h1, 8'h01);
   bus(4'h8, 1'h1, 8'h00);
   bus(4'h5, 1'h1, 8'h0C);
   bus(4'h2, 1'h1, 8'h06);
   repeat (160) @(posedge core_clk);
   meas(66, 2, 0);
end
endtask
task t_hold;
begin
   bus(4'h2, 1'h1, 8'h00);
   bus(4'h3, 1'h1, 8'h07);
   rchk(4'h4, 8'h02);
   bus(4'h5, 1'h1, 8'h00);
   rchk(4'h5, 8'h00);
   `CHK("off level", 1'h0, oneOut)
end
endtask
task finish_test;
begin
   $display("compares %0d mismatches %0d", compares, mismatches);
   if (mismatches == 0 && compares > 0)
   begin
      $display("Result: passed");
   end
   else
   begin
      $display("Result: failed");
   end
   $finish;
end
endtask
initial
begin
   repeat (6) @(posedge core_clk);
   arst_n <= 1'h1;
   t_regs;
   t_fast;
   t_mid;
   t_slow;
   t_hold;
   finish_test;
end
endmodule // ptb_pwm_timebase_tb_top
bind ptb_pwm_timebase ptb_pwm_timebase_checker chk
(
   .core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .pwmOneOut(pwmOneOut),
   .pwmOneOe_n(pwmOneOe_n), .pwmTwoOut(pwmTwoOut), .pwmTwoOe_n(pwmTwoOe_n)
);
